// ---- inc/inj_seq_pkg.sv ----
// Constants, register map and types for the injection and interrupt sequencer
package inj_seq_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] OFS_INJ_CFG = 8'h00;
    localparam logic [7:0] OFS_INJ_RESULT = 8'h04;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h08;
    localparam logic [7:0] OFS_IRQ_FORCE = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_IRQ_GATED = 8'h14;
    localparam logic [7:0] OFS_SAMPLE_CTRL = 8'h18;
    localparam logic [7:0] OFS_SEQ_CTRL = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Injection configuration fields
    localparam int CFG_GO_BIT = 31;
    localparam int CFG_FOLLOW_BIT = 30;
    localparam int CFG_AVG_BIT = 10;
    localparam int CFG_SAMPLE_LSB = 8;
    localparam int CFG_ALT_RES_BIT = 6;
    localparam int CFG_DIFF_BIT = 5;
    localparam int CFG_PIN_LSB = 0;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h4000_077F;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // Interrupt flag positions
    localparam int IRQ_SCAN_DONE = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_SW_CLASH = 2;
    localparam int IRQ_HW_CLASH = 3;
    localparam int IRQ_INJ_CLASH = 4;
    localparam int IRQ_INJ_DONE = 5;
    localparam int IRQ_INJ_WINDOW = 6;
    localparam int IRQ_INJ_CLIP = 7;
    localparam int IRQ_RANGE = 8;
    localparam int IRQ_CLIP = 9;
    localparam int NUM_IRQ = 10;
    localparam logic [9:0] IRQ_RESET = 10'h000;
    // Result mirror bits
    localparam int RES_VALID_BIT = 31;
    localparam int RES_WINDOW_BIT = 30;
    localparam int RES_CLIP_BIT = 29;
    localparam int RES_CLASH_BIT = 28;
    // Control bits
    localparam int SMP_PIN_EN_BIT = 31;
    localparam int SEQ_ENABLE_BIT = 0;
    localparam int SEQ_SW_TRIG_BIT = 1;
    // Width of the scan-done pin pulse in cycles
    localparam logic [1:0] PULSE_CYCLES = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SCAN, ST_INJ, ST_INJ_WAIT
    } seq_state_t;
endpackage : inj_seq_pkg

// ---- design/irq_flag_bank.sv ----
// Sticky interrupt flags with force, write-one-to-clear, mask and gated view
`timescale 1ns/1ps
module irq_flag_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Hardware events and software access
    input wire logic [inj_seq_pkg::NUM_IRQ-1:0] event_set,
    input wire logic [inj_seq_pkg::NUM_IRQ-1:0] force_set,
    input wire logic [inj_seq_pkg::NUM_IRQ-1:0] clear_w1c,
    input wire logic [inj_seq_pkg::NUM_IRQ-1:0] irq_enable,
    // Flags and gated view
    output logic [inj_seq_pkg::NUM_IRQ-1:0] flags,
    output logic [inj_seq_pkg::NUM_IRQ-1:0] gated
);
    genvar i;
    // One sticky bit per source; set wins over clear
    generate
        for (i = 0; i < inj_seq_pkg::NUM_IRQ; i++) begin : g_flag
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    flags[i] <= 1'b0;
                end else if (event_set[i] || force_set[i]) begin
                    flags[i] <= 1'b1;
                end else if (clear_w1c[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Masked view of pending flags
    assign gated = flags & irq_enable;
endmodule : irq_flag_bank

// ---- design/pulse_stretch.sv ----
// Stretches a one-cycle event into a fixed-length output pulse
`timescale 1ns/1ps
module pulse_stretch (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Trigger and enable
    input wire logic trig,
    input wire logic enable,
    // Stretched pulse
    output logic pulse_q
);
    logic [1:0] cnt_q;
    // Counts down the pulse length after each trigger
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            pulse_q <= 1'b0;
        end else if (trig && enable) begin
            cnt_q <= inj_seq_pkg::PULSE_CYCLES - 2'h1;
            pulse_q <= 1'b1;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            pulse_q <= 1'b1;
        end else begin
            pulse_q <= 1'b0;
        end
    end
endmodule : pulse_stretch

// ---- design/inj_sequencer.sv ----
// Injection channel sequencing, result register and interrupt control
`timescale 1ns/1ps
// How it works
// - Injection starts only from the software go bit, never from hardware triggers.
// - Injection result is a single register; no overrun flag for it.
// - Config selects pin, differential, resolution, one of four sample times, averaging.
// - Setting config bit 31 requests an injection conversion.
// - Follow-scan during a scan: inject right after scan, no clash.
// - Follow-scan while idle: inject after the next regular scan ends.
// - No follow-scan and idle: injection starts immediately.
// - No follow-scan during scan: inject after scan and set clash flag.
// - Software scan trigger during plain injection sets software clash, scan waits.
// - Injection done writes result, sets done flag, clears go bit.
// - Result register mirrors valid, window, clip and clash flags.
// - Disabling sequencer clears go bit at once if it was set.
// - In continuous mode the injection conversion is inserted into the sequence.
// - Injection has maskable done, window and clip flags, no overrun.
// - Flags: scan done, overrun, clashes, injection done, range, clip.
// - Interrupt output is high when any flag has its enable bit set.
// - Gated view register reads flags AND enables.
// - Writing one to force register raises the matching flag.
// - Scan completion sets scan-done flag; software clears it after reading.
// - Sample control bit 31 sends scan-done pulse out for two cycles.
// - Non-continuous trigger during busy scan sets clash and is delayed.
// - Scan completion while scan-done still set raises overrun.
module inj_sequencer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata_q,
    // Hardware scan trigger and continuous mode
    input wire logic hw_trig,
    input wire logic cont_mode,
    // Converter core
    output logic scan_start_q,
    output logic inj_start_q,
    output logic [31:0] inj_cfg_out_q,
    input wire logic scan_last_valid,
    input wire logic scan_end,
    input wire logic range_hit,
    input wire logic clip_hit,
    input wire logic inj_end,
    input wire logic [15:0] inj_data,
    input wire logic inj_window,
    input wire logic inj_clip,
    // Outputs
    output logic irq_q,
    output logic scan_done_pin_q,
    output logic busy_q
);
    logic [31:0] injection_config_reg_q;
    logic [31:0] injection_result_reg_q;
    logic [31:0] sampling_control_reg_q;
    logic [inj_seq_pkg::NUM_IRQ-1:0] irq_enable_reg_q;
    logic seq_en_q;
    logic sw_pend_q;
    logic hw_pend_q;
    logic inj_follow_q;
    logic inj_armed_q;
    inj_seq_pkg::seq_state_t state_q;
    logic [inj_seq_pkg::NUM_IRQ-1:0] ev;
    logic [inj_seq_pkg::NUM_IRQ-1:0] force_set;
    logic [inj_seq_pkg::NUM_IRQ-1:0] clear_w1c;
    logic [inj_seq_pkg::NUM_IRQ-1:0] flags;
    logic [inj_seq_pkg::NUM_IRQ-1:0] gated;
    logic [inj_seq_pkg::NUM_IRQ-1:0] flags_d;
    logic go_bit;
    logic follow_bit;
    logic sw_trig_wr;
    logic scan_req;
    logic in_scan;
    logic in_inj;
    logic seq_dis_wr;

    // Returns true when a write targets the given offset
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic we);
        return we && (a == ofs);
    endfunction : wr_hit

    assign go_bit = injection_config_reg_q[inj_seq_pkg::CFG_GO_BIT];
    assign follow_bit = injection_config_reg_q[inj_seq_pkg::CFG_FOLLOW_BIT];
    assign sw_trig_wr = wr_hit(addr, inj_seq_pkg::OFS_SEQ_CTRL, wr_en)
                        && wdata[inj_seq_pkg::SEQ_SW_TRIG_BIT];
    assign seq_dis_wr = wr_hit(addr, inj_seq_pkg::OFS_SEQ_CTRL, wr_en)
                        && !wdata[inj_seq_pkg::SEQ_ENABLE_BIT];
    assign in_scan = (state_q == inj_seq_pkg::ST_SCAN);
    assign in_inj = (state_q == inj_seq_pkg::ST_INJ);
    // A regular scan is wanted: pending trigger or continuous running
    assign scan_req = sw_pend_q || hw_pend_q || cont_mode;
    // Flag values after this edge; set wins over a write-one clear
    assign flags_d = ev | force_set | (flags & ~clear_w1c);

    // Sequencer enable and sample control
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seq_en_q <= 1'b0;
            sampling_control_reg_q <= 32'h0000_0000;
        end else begin
            if (wr_hit(addr, inj_seq_pkg::OFS_SEQ_CTRL, wr_en)) begin
                seq_en_q <= wdata[inj_seq_pkg::SEQ_ENABLE_BIT];
            end
            if (wr_hit(addr, inj_seq_pkg::OFS_SAMPLE_CTRL, wr_en)) begin
                sampling_control_reg_q <= wdata;
            end
        end
    end

    // Injection configuration; go bit set by software only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            injection_config_reg_q <= inj_seq_pkg::CFG_RESET;
        end else begin
            if (wr_hit(addr, inj_seq_pkg::OFS_INJ_CFG, wr_en)) begin
                injection_config_reg_q <= (wdata & inj_seq_pkg::CFG_WRITE_MASK)
                    | ({31'h0, go_bit} << inj_seq_pkg::CFG_GO_BIT)
                    | ({31'h0, wdata[inj_seq_pkg::CFG_GO_BIT]} << inj_seq_pkg::CFG_GO_BIT);
            end
            if (seq_dis_wr && go_bit) begin
                injection_config_reg_q[inj_seq_pkg::CFG_GO_BIT] <= 1'b0;
            end else if (in_inj && inj_end) begin
                injection_config_reg_q[inj_seq_pkg::CFG_GO_BIT] <= 1'b0;
            end
        end
    end

    // Pending regular triggers; clash when arriving while busy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sw_pend_q <= 1'b0;
            hw_pend_q <= 1'b0;
        end else if (!seq_en_q) begin
            sw_pend_q <= 1'b0;
            hw_pend_q <= 1'b0;
        end else begin
            if (sw_trig_wr) begin
                sw_pend_q <= 1'b1;
            end else if (scan_start_q && sw_pend_q) begin
                sw_pend_q <= 1'b0;
            end
            if (hw_trig) begin
                hw_pend_q <= 1'b1;
            end else if (scan_start_q && hw_pend_q && !sw_pend_q) begin
                hw_pend_q <= 1'b0;
            end
        end
    end

    // Injection arming: follow-scan waits for a scan end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            inj_armed_q <= 1'b0;
            inj_follow_q <= 1'b0;
        end else if (!go_bit || !seq_en_q) begin
            inj_armed_q <= 1'b0;
            inj_follow_q <= 1'b0;
        end else if (in_scan && scan_end) begin
            inj_armed_q <= 1'b1;
            inj_follow_q <= follow_bit;
        end else if (!follow_bit && !in_scan) begin
            inj_armed_q <= 1'b1;
            inj_follow_q <= 1'b0;
        end
    end

    // Main sequencer state machine
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= inj_seq_pkg::ST_IDLE;
            scan_start_q <= 1'b0;
            inj_start_q <= 1'b0;
            busy_q <= 1'b0;
            inj_cfg_out_q <= 32'h0000_0000;
        end else begin
            scan_start_q <= 1'b0;
            inj_start_q <= 1'b0;
            case (state_q)
                inj_seq_pkg::ST_IDLE: begin
                    if (seq_en_q && inj_armed_q && go_bit) begin
                        state_q <= inj_seq_pkg::ST_INJ;
                        inj_start_q <= 1'b1;
                        inj_cfg_out_q <= injection_config_reg_q;
                        busy_q <= 1'b1;
                    end else if (seq_en_q && scan_req) begin
                        state_q <= inj_seq_pkg::ST_SCAN;
                        scan_start_q <= 1'b1;
                        busy_q <= 1'b1;
                    end else begin
                        busy_q <= 1'b0;
                    end
                end
                inj_seq_pkg::ST_SCAN: begin
                    if (!seq_en_q || scan_end) begin
                        state_q <= inj_seq_pkg::ST_IDLE;
                    end
                end
                inj_seq_pkg::ST_INJ: begin
                    if (!seq_en_q || inj_end) begin
                        state_q <= inj_seq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= inj_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Injection result with mirror bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            injection_result_reg_q <= 32'h0000_0000;
        end else begin
            if (in_inj && inj_end) begin
                injection_result_reg_q[15:0] <= inj_data;
            end
            // Mirrors track the flags' next value so they never lag a flag
            injection_result_reg_q[inj_seq_pkg::RES_VALID_BIT] <=
                flags_d[inj_seq_pkg::IRQ_INJ_DONE];
            injection_result_reg_q[inj_seq_pkg::RES_WINDOW_BIT] <=
                flags_d[inj_seq_pkg::IRQ_INJ_WINDOW];
            injection_result_reg_q[inj_seq_pkg::RES_CLIP_BIT] <=
                flags_d[inj_seq_pkg::IRQ_INJ_CLIP];
            injection_result_reg_q[inj_seq_pkg::RES_CLASH_BIT] <=
                flags_d[inj_seq_pkg::IRQ_INJ_CLASH];
        end
    end

    // Hardware events feeding the flag bank
    always_comb begin
        ev = '0;
        ev[inj_seq_pkg::IRQ_SCAN_DONE] = in_scan && scan_end;
        ev[inj_seq_pkg::IRQ_OVERRUN] = in_scan && scan_end
                                       && flags[inj_seq_pkg::IRQ_SCAN_DONE];
        ev[inj_seq_pkg::IRQ_SW_CLASH] = sw_trig_wr && seq_en_q
                                        && (in_scan || (in_inj && !inj_follow_q));
        ev[inj_seq_pkg::IRQ_HW_CLASH] = hw_trig && seq_en_q && (in_scan || in_inj);
        ev[inj_seq_pkg::IRQ_INJ_CLASH] = wr_hit(addr, inj_seq_pkg::OFS_INJ_CFG, wr_en)
            && wdata[inj_seq_pkg::CFG_GO_BIT] && !wdata[inj_seq_pkg::CFG_FOLLOW_BIT]
            && in_scan && seq_en_q;
        ev[inj_seq_pkg::IRQ_INJ_DONE] = in_inj && inj_end;
        ev[inj_seq_pkg::IRQ_INJ_WINDOW] = in_inj && inj_end && inj_window;
        ev[inj_seq_pkg::IRQ_INJ_CLIP] = in_inj && inj_end && inj_clip;
        ev[inj_seq_pkg::IRQ_RANGE] = in_scan && range_hit;
        ev[inj_seq_pkg::IRQ_CLIP] = in_scan && clip_hit;
    end

    // Force and clear strobes from register writes
    always_comb begin
        force_set = '0;
        clear_w1c = '0;
        if (wr_hit(addr, inj_seq_pkg::OFS_IRQ_FORCE, wr_en)) begin
            force_set = wdata[inj_seq_pkg::NUM_IRQ-1:0];
        end else if (wr_hit(addr, inj_seq_pkg::OFS_IRQ_FLAGS, wr_en)) begin
            clear_w1c = wdata[inj_seq_pkg::NUM_IRQ-1:0];
        end
    end

    irq_flag_bank u_flags (
        .mclk(mclk),
        .rst_n(rst_n),
        .event_set(ev),
        .force_set(force_set),
        .clear_w1c(clear_w1c),
        .irq_enable(irq_enable_reg_q),
        .flags(flags),
        .gated(gated)
    );

    // Interrupt enable register and interrupt output
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_enable_reg_q <= inj_seq_pkg::IRQ_RESET;
            irq_q <= 1'b0;
        end else begin
            if (wr_hit(addr, inj_seq_pkg::OFS_IRQ_ENABLE, wr_en)) begin
                irq_enable_reg_q <= wdata[inj_seq_pkg::NUM_IRQ-1:0];
            end
            irq_q <= |gated;
        end
    end

    // Scan-done pin pulse, starting one cycle after the last channel strobe
    pulse_stretch u_pin (
        .mclk(mclk),
        .rst_n(rst_n),
        .trig(scan_last_valid && in_scan),
        .enable(sampling_control_reg_q[inj_seq_pkg::SMP_PIN_EN_BIT]),
        .pulse_q(scan_done_pin_q)
    );

    // Read data, one cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            if (addr == inj_seq_pkg::OFS_INJ_CFG) begin
                rdata_q <= injection_config_reg_q;
            end else if (addr == inj_seq_pkg::OFS_INJ_RESULT) begin
                rdata_q <= injection_result_reg_q;
            end else if (addr == inj_seq_pkg::OFS_IRQ_FLAGS) begin
                rdata_q <= {22'h0, flags};
            end else if (addr == inj_seq_pkg::OFS_IRQ_FORCE) begin
                rdata_q <= {22'h0, flags};
            end else if (addr == inj_seq_pkg::OFS_IRQ_ENABLE) begin
                rdata_q <= {22'h0, irq_enable_reg_q};
            end else if (addr == inj_seq_pkg::OFS_IRQ_GATED) begin
                rdata_q <= {22'h0, gated};
            end else if (addr == inj_seq_pkg::OFS_SAMPLE_CTRL) begin
                rdata_q <= sampling_control_reg_q;
            end else if (addr == inj_seq_pkg::OFS_SEQ_CTRL) begin
                rdata_q <= {31'h0, seq_en_q};
            end else if (addr == inj_seq_pkg::OFS_STATUS) begin
                rdata_q <= {29'h0, inj_armed_q, in_inj, in_scan};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
endmodule : inj_sequencer

// ---- sim/inj_sequencer_assertions.sv ----
// Port-level checker for the injection and interrupt sequencer
`timescale 1ns/1ps
module inj_sequencer_check (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata_q,
    // Converter side
    input wire logic scan_start_q,
    input wire logic inj_start_q,
    input wire logic scan_last_valid,
    input wire logic scan_end,
    input wire logic inj_end,
    // Outputs
    input wire logic irq_q,
    input wire logic scan_done_pin_q,
    input wire logic busy_q
);
    logic scan_run_q;
    logic inj_run_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Track which conversion the core is busy with
    always_ff @(posedge mclk) begin
        if (!rst_n)
            scan_run_q <= 1'b0;
        else if (scan_start_q)
            scan_run_q <= 1'b1;
        else if (scan_end)
            scan_run_q <= 1'b0;
    end
    always_ff @(posedge mclk) begin
        if (!rst_n)
            inj_run_q <= 1'b0;
        else if (inj_start_q)
            inj_run_q <= 1'b1;
        else if (inj_end)
            inj_run_q <= 1'b0;
    end
    // Pin pulse is exactly two cycles wide
    sequence pin_two_s;
        scan_done_pin_q [*2] ##1 !scan_done_pin_q;
    endsequence
    a_pin_two_cycles: assert property ($rose(scan_done_pin_q) |-> pin_two_s)
        else $error("scan done pin pulse not two cycles");
    a_pin_at_valid: assert property ($rose(scan_done_pin_q) |->
        $past(scan_last_valid) || $past(scan_last_valid, 2))
        else $error("scan done pin not aligned to last data valid");
    a_scan_start_pulse: assert property (scan_start_q |=> !scan_start_q)
        else $error("scan start longer than one cycle");
    a_inj_start_pulse: assert property (inj_start_q |=> !inj_start_q)
        else $error("injection start longer than one cycle");
    a_busy_with_start: assert property ((scan_start_q || inj_start_q) |-> busy_q)
        else $error("start issued while not busy");
    a_scan_waits_inj: assert property (scan_start_q |-> !inj_run_q)
        else $error("scan started during injection");
    a_inj_after_scan: assert property (inj_start_q |-> !scan_run_q)
        else $error("injection started during scan");
    a_read_one_cycle: assert property (rdata_q != 32'h0000_0000 |-> $past(rd_en))
        else $error("read data outside its cycle");
    a_irq_drop_cause: assert property ($fell(irq_q) |-> $past(wr_en) || $past(wr_en, 2))
        else $error("interrupt dropped without a write");
endmodule : inj_sequencer_check

bind inj_sequencer inj_sequencer_check inj_sequencer_check_inst (.mclk, .rst_n, .wr_en,
    .rd_en, .rdata_q, .scan_start_q, .inj_start_q, .scan_last_valid, .scan_end, .inj_end,
    .irq_q, .scan_done_pin_q, .busy_q);

// ---- sim/conv_core_model.sv ----
// Behavioural model of the converter core behind the sequencer
`timescale 1ns/1ps
module conv_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Starts and bench controls
    input wire logic scan_start_q,
    input wire logic inj_start_q,
    input wire logic slow,
    input wire logic hits,
    input wire logic [15:0] inj_val,
    input wire logic [1:0] inj_flags,
    // Conversion results
    output logic scan_last_valid,
    output logic scan_end,
    output logic range_hit,
    output logic clip_hit,
    output logic inj_end,
    output logic [15:0] inj_data,
    output logic inj_window,
    output logic inj_clip
);
    int scan_cnt;
    int inj_cnt;
    // Count each conversion down and strobe its end; data wanders when not valid
    always @(posedge mclk) begin
        scan_last_valid <= scan_cnt == 1;
        scan_end <= scan_cnt == 1;
        range_hit <= scan_cnt == 1 && hits;
        clip_hit <= scan_cnt == 1 && hits;
        inj_end <= inj_cnt == 1;
        inj_window <= inj_cnt == 1 && inj_flags[0];
        inj_clip <= inj_cnt == 1 && inj_flags[1];
        if (!rst_n) begin
            scan_cnt <= 0;
            inj_cnt <= 0;
            inj_data <= 16'h5A5A;
        end else begin
            inj_data <= inj_cnt == 1 ? inj_val : ~inj_data;
            scan_cnt <= scan_start_q ? (slow ? 20 : 6) : (scan_cnt > 0 ? scan_cnt - 1 : 0);
            inj_cnt <= inj_start_q ? (slow ? 20 : 6) : (inj_cnt > 0 ? inj_cnt - 1 : 0);
        end
    end
endmodule : conv_core_model

// ---- sim/inj_sequencer_test.sv ----
// Self-checking bench for the injection and interrupt sequencer
`timescale 1ns/1ps
module inj_sequencer_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic hw_trig = 1'b0;
    logic cont_mode = 1'b0;
    logic slow = 1'b0;
    logic hits = 1'b0;
    logic [15:0] inj_val = 16'h0000;
    logic [1:0] inj_flags = 2'b00;
    logic [31:0] rdata_q, inj_cfg_out_q;
    logic [15:0] inj_data;
    logic scan_start_q, inj_start_q, scan_last_valid, scan_end, range_hit, clip_hit;
    logic inj_end, inj_window, inj_clip, irq_q, scan_done_pin_q, busy_q;
    int miscompares = 0;
    int n_checks = 0;
    int pin_cnt = 0;
    int i;
    inj_sequencer inj_sequencer_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .hw_trig(hw_trig),
        .cont_mode(cont_mode),
        .scan_start_q(scan_start_q), .inj_start_q(inj_start_q), .inj_cfg_out_q(inj_cfg_out_q),
        .scan_last_valid(scan_last_valid), .scan_end(scan_end), .range_hit(range_hit),
        .clip_hit(clip_hit), .inj_end(inj_end), .inj_data(inj_data), .inj_window(inj_window),
        .inj_clip(inj_clip), .irq_q(irq_q), .scan_done_pin_q(scan_done_pin_q), .busy_q(busy_q));
    conv_core_model conv_core_model_inst (.mclk(mclk), .rst_n(rst_n),
        .scan_start_q(scan_start_q), .inj_start_q(inj_start_q), .slow(slow), .hits(hits),
        .inj_val(inj_val), .inj_flags(inj_flags), .scan_last_valid(scan_last_valid),
        .scan_end(scan_end), .range_hit(range_hit), .clip_hit(clip_hit), .inj_end(inj_end),
        .inj_data(inj_data), .inj_window(inj_window), .inj_clip(inj_clip));
    // Clock and pin pulse counter
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (scan_done_pin_q === 1'b1)
            pin_cnt++;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(what, rdata_q, exp);
    endtask : rd
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Wait until the sequencer has stayed idle for eight cycles
    task automatic wait_idle;
        int q;
        q = 0;
        for (int n = 0; n < 2000 && q < 8; n++) begin
            @(posedge mclk);
            q = busy_q === 1'b0 ? q + 1 : 0;
        end
        if (q < 8) begin
            miscompares++;
            $display("[ERR] sequencer never went idle");
            wrap_up();
        end
    endtask : wait_idle
    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        $display("[ERR] run timed out");
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (i = 0; i < 10; i++)
            rd(8'(4 * i), 32'h0000_0000, "reset value");
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0000_0000, "unmapped");
        for (i = 0; i < 10; i++) begin
            wr(8'h0C, 32'h0000_0001 << i);
            rd(8'h08, 32'h0000_0001 << i, "forced flag");
            chk("irq masked", 32'(irq_q), 32'h0000_0000);
            wr(8'h08, 32'h0000_0001 << i);
        end
        wr(8'h10, 32'h0000_0155);
        wr(8'h0C, 32'h0000_03FF);
        rd(8'h14, 32'h0000_0155, "gated view");
        chk("irq raised", 32'(irq_q), 32'h0000_0001);
        wr(8'h10, 32'h0000_03FF);
        wr(8'h08, 32'h0000_03FF);
        rd(8'h08, 32'h0000_0000, "flags cleared");
        chk("irq cleared", 32'(irq_q), 32'h0000_0000);
        wr(8'h1C, 32'h0000_0001);
        // Plain injection while idle
        inj_val <= 16'hABCD;
        inj_flags <= 2'b01;
        wr(8'h00, 32'h8000_0765);
        wait_idle();
        chk("config to core", inj_cfg_out_q & 32'h0000_077F, 32'h0000_0765);
        rd(8'h00, 32'h0000_0765, "go cleared");
        rd(8'h04, 32'hC000_ABCD, "inj result");
        rd(8'h08, 32'h0000_0060, "inj flags");
        chk("irq on done", 32'(irq_q), 32'h0000_0001);
        wr(8'h08, 32'h0000_03FF);
        rd(8'h04, 32'h0000_ABCD, "valid mirror");
        // Injection during a slow scan, then a software trigger during the injection
        slow <= 1'b1;
        hits <= 1'b1;
        inj_val <= 16'h1234;
        inj_flags <= 2'b10;
        wr(8'h1C, 32'h0000_0003);
        wr(8'h00, 32'h8000_0001);
        for (i = 0; i < 200 && inj_start_q !== 1'b1; i++)
            @(posedge mclk);
        chk("inj start wait", 32'(i < 200), 32'h0000_0001);
        if (i == 200)
            wrap_up();
        wr(8'h1C, 32'h0000_0003);
        wait_idle();
        rd(8'h08, 32'h0000_03B7, "clash flags");
        rd(8'h04, 32'hB000_1234, "clash mirror");
        wr(8'h08, 32'h0000_03FF);
        // Tailgating with the pin output and a hardware trigger mid-scan
        hits <= 1'b0;
        inj_val <= 16'h0FFF;
        inj_flags <= 2'b01;
        pin_cnt = 0;
        wr(8'h18, 32'h8000_0000);
        wr(8'h00, 32'hC000_0003);
        rd(8'h00, 32'hC000_0003, "deferred go");
        chk("idle while deferred", 32'(busy_q), 32'h0000_0000);
        wr(8'h1C, 32'h0000_0003);
        repeat (2) @(posedge mclk);
        hw_trig <= 1'b1;
        @(posedge mclk);
        hw_trig <= 1'b0;
        wait_idle();
        rd(8'h08, 32'h0000_006B, "tailgate flags");
        chk("pin cycles", pin_cnt, 32'h0000_0004);
        wr(8'h18, 32'h0000_0000);
        wr(8'h08, 32'h0000_03FF);
        // Continuous scan with a tailgated injection inserted after it
        cont_mode <= 1'b1;
        wr(8'h00, 32'hC000_0002);
        cont_mode <= 1'b0;
        wait_idle();
        rd(8'h08, 32'h0000_0061, "inserted flags");
        chk("inserted cfg", inj_cfg_out_q, 32'hC000_0002);
        // Disable drops a pending go bit
        wr(8'h00, 32'hC000_0001);
        wr(8'h1C, 32'h0000_0000);
        rd(8'h00, 32'h4000_0001, "go dropped");
        wrap_up();
    end
endmodule : inj_sequencer_test
